// [hdl/ftw_top.sv]
// Purpose: Secondary arbiter priority groups and primary flow-through wait control.
// Assumes: AXI4-Lite slave on clk; the PCI clock and status pins are asynchronous inputs.
// Notes: Wait counts are measured in PCI clock rising edges found by sampling pci_clk.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
module ftw_top
  import ftw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pci_clk,
  input wire logic wr_flow_active,
  input wire logic wr_one_entry_left,
  input wire logic wr_data_avail,
  input wire logic rd_flow_active,
  input wire logic rd_one_entry_left,
  input wire logic rd_space_avail,
  output logic [REQ_N-1:0] req_high_group,
  output logic own_high_group,
  output logic wr_irdy_hold,
  output logic wr_cycle_end,
  output logic rd_trdy_hold,
  output logic rd_cycle_end
);
  localparam int NSYNC = 7;
  // Slot of each pin in the synchroniser vector.
  localparam int SYNC_PCLK = 0;
  localparam int SYNC_WR_ACT = 1;
  localparam int SYNC_WR_ONE = 2;
  localparam int SYNC_WR_AVAIL = 3;
  localparam int SYNC_RD_ACT = 4;
  localparam int SYNC_RD_ONE = 5;
  localparam int SYNC_RD_AVAIL = 6;

  // Two-stage synchronisers for every pin; the first stage feeds only the second.
  logic [NSYNC-1:0] pin_in;
  logic [NSYNC-1:0] sync1_reg, sync1_next;
  logic [NSYNC-1:0] sync2_reg, sync2_next;
  logic pclk_old_reg, pclk_old_next;
  logic pci_tick;

  assign pin_in[SYNC_PCLK] = pci_clk;
  assign pin_in[SYNC_WR_ACT] = wr_flow_active;
  assign pin_in[SYNC_WR_ONE] = wr_one_entry_left;
  assign pin_in[SYNC_WR_AVAIL] = wr_data_avail;
  assign pin_in[SYNC_RD_ACT] = rd_flow_active;
  assign pin_in[SYNC_RD_ONE] = rd_one_entry_left;
  assign pin_in[SYNC_RD_AVAIL] = rd_space_avail;

  always_comb begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
    pclk_old_next = sync2_reg[SYNC_PCLK];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Both stages start at the idle low level of every pin.
      sync1_reg <= '0;
      sync2_reg <= '0;
      pclk_old_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      pclk_old_reg <= pclk_old_next;
    end
  end

  // One tick per PCI clock rising edge; the PCI clock must run below half of clk.
  assign pci_tick = sync2_reg[SYNC_PCLK] & ~pclk_old_reg;

  // Register file.
  logic [ARB_W-1:0] arb_reg, arb_next;
  logic [FLOW_W-1:0] flow_reg, flow_next;

  // Write channel: address and data may arrive in either order.
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [AXI_AW-1:0] aw_addr_reg, aw_addr_next;
  logic [AXI_DW-1:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;

  // Read channel.
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [AXI_DW-1:0] rdata_reg, rdata_next;

  logic aw_take, w_take, ar_take, wr_go;
  logic [AXI_AW-1:0] wa_word, ra_word;
  logic [ARB_W-1:0] arb_bmask;
  logic [FLOW_W-1:0] flow_bmask;

  assign aw_take = s_axi_awvalid & awready_reg;
  assign w_take = s_axi_wvalid & wready_reg;
  assign ar_take = s_axi_arvalid & arready_reg;
  // A write lands only when both halves are held and the last answer is gone.
  assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wa_word = {aw_addr_reg[AXI_AW-1:2], 2'b00};
  assign ra_word = {s_axi_araddr[AXI_AW-1:2], 2'b00};
  assign arb_bmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign flow_bmask = {8{w_strb_reg[0]}};

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arb_next = arb_reg;
    flow_next = flow_reg;
    if (aw_take) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    // Data may come before or after its address; each waits in its own slot.
    if (w_take) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (wa_word == ARB_ADDR) begin
        // Only bits 9:0 are writable; 15:10 stay zero.
        arb_next = (arb_reg & ~(ARB_WMASK & arb_bmask)) |
                   (w_data_reg[ARB_W-1:0] & ARB_WMASK & arb_bmask);
      end else if (wa_word == FLOW_ADDR) begin
        flow_next = (flow_reg & ~(FLOW_WMASK & flow_bmask)) |
                    (w_data_reg[FLOW_W-1:0] & FLOW_WMASK & flow_bmask);
      end else begin
        // Unmapped writes change nothing but are still answered.
        bresp_next = RESP_DECERR;
      end
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // A slot is offered again once its item has been consumed by a write.
    awready_next = ~aw_full_next;
    wready_next = ~w_full_next;
  end

  // Read data are captured at address accept, so a later write cannot tear them.
  always_comb begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (ar_take) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      if (ra_word == ARB_ADDR) begin
        rdata_next = AXI_DW'(arb_reg);
      end else if (ra_word == FLOW_ADDR) begin
        rdata_next = AXI_DW'(flow_reg & FLOW_WMASK);
      end else begin
        // Unmapped reads answer zero so no stale data leaks out.
        rdata_next = '0;
        rresp_next = RESP_DECERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      arb_reg <= ARB_RESET;
      flow_reg <= FLOW_RESET;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      arb_reg <= arb_next;
      flow_reg <= flow_next;
    end
  end

  // Priority group outputs are registered copies so they never glitch on a write.
  logic [REQ_N-1:0] grp_reg, grp_next;
  logic own_reg, own_next;

  always_comb begin
    grp_next = arb_reg[REQ_N-1:0];
    own_next = arb_reg[OWN_PRIO_BIT];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      grp_reg <= '0;
      // The own port starts in the high group, as the register does.
      own_reg <= 1'b1;
    end else begin
      grp_reg <= grp_next;
      own_reg <= own_next;
    end
  end

  // Channel 0 is the posted write path, channel 1 the delayed read path.
  // Both share one PCI tick so their wait counts use the same time base.
  localparam int NCH = 2;
  localparam int CH_WR = 0;
  localparam int CH_RD = 1;
  logic [NCH-1:0] ch_active;
  logic [NCH-1:0] ch_one_left;
  logic [NCH-1:0] ch_refill;
  logic [NCH-1:0][WAIT_W-1:0] ch_limit;
  logic [NCH-1:0] ch_hold;
  logic [NCH-1:0] ch_term;

  // A write stalls for initiator data; a read stalls for queue space.
  assign ch_active = {sync2_reg[SYNC_RD_ACT], sync2_reg[SYNC_WR_ACT]};
  assign ch_one_left = {sync2_reg[SYNC_RD_ONE], sync2_reg[SYNC_WR_ONE]};
  assign ch_refill = {sync2_reg[SYNC_RD_AVAIL], sync2_reg[SYNC_WR_AVAIL]};
  assign ch_limit = {flow_reg[RD_WAIT_LSB +: WAIT_W],
                     flow_reg[WR_WAIT_LSB +: WAIT_W]};

  // A stall on one channel never holds the other.
  for (genvar ci = 0; ci < NCH; ci++) begin : g_wait
    ftw_wait_ctl u_wait (
      .clk(clk),
      .rstn(rstn),
      .tick(pci_tick),
      .active(ch_active[ci]),
      .one_left(ch_one_left[ci]),
      .refill(ch_refill[ci]),
      .limit(ch_limit[ci]),
      .hold(ch_hold[ci]),
      .term(ch_term[ci])
    );
  end

  // Each channel ends at most once per active period.
  assign wr_irdy_hold = ch_hold[CH_WR];
  assign wr_cycle_end = ch_term[CH_WR];
  assign rd_trdy_hold = ch_hold[CH_RD];
  assign rd_cycle_end = ch_term[CH_RD];

  // Every bus output is a register of its own.
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign req_high_group = grp_reg;
  assign own_high_group = own_reg;
endmodule

// [hdl/ftw_pkg.sv]
// Purpose: Shared constants for the arbiter priority and flow-through wait control block.
// Assumes: AXI4-Lite register access, 32-bit data, one register per aligned word.
// Notes: Wait codes count PCI clock rising edges, not system clocks.
package ftw_pkg;
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  // Printed offsets are indices; byte address is four times the index.
  localparam logic [7:0] ARB_IDX = 8'h42;
  localparam logic [7:0] FLOW_IDX = 8'h44;
  localparam logic [AXI_AW-1:0] ARB_ADDR = AXI_AW'({ARB_IDX, 2'b00});
  localparam logic [AXI_AW-1:0] FLOW_ADDR = AXI_AW'({FLOW_IDX, 2'b00});
  localparam int ARB_W = 16;
  localparam int FLOW_W = 8;
  localparam int REQ_N = 9;
  localparam int OWN_PRIO_BIT = 9;
  localparam logic [ARB_W-1:0] ARB_RESET = 16'h0200;
  localparam logic [ARB_W-1:0] ARB_WMASK = 16'h03FF;
  localparam logic [FLOW_W-1:0] FLOW_RESET = 8'h00;
  localparam logic [FLOW_W-1:0] FLOW_WMASK = 8'h77;
  localparam int WAIT_W = 3;
  localparam int WR_WAIT_LSB = 0;
  localparam int RD_WAIT_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    FTW_IDLE = 2'b00,
    FTW_WAIT = 2'b01,
    FTW_END = 2'b11
  } ftw_state_t;
endpackage

// [hdl/ftw_wait_ctl.sv]
// Purpose: One flow-through wait counter: stalls, waits up to a code of link clocks, then ends.
// Assumes: All inputs already synchronised; tick marks one link clock rising edge.
// Notes: Code 0 ends at once; codes 1 to 7 wait that many link clocks.
`timescale 1ns/10ps
module ftw_wait_ctl
  import ftw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic active,
  input wire logic one_left,
  input wire logic refill,
  input wire logic [WAIT_W-1:0] limit,
  output logic hold,
  output logic term
);
  ftw_state_t state_reg, state_next;
  logic [WAIT_W-1:0] cnt_reg, cnt_next;
  logic hold_reg, hold_next;
  logic term_reg, term_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    hold_next = hold_reg;
    term_next = 1'b0;
    unique case (state_reg)
      FTW_IDLE: begin
        if (tick && active && one_left && !refill) begin
          if (limit == '0) begin
            state_next = FTW_END;
            term_next = 1'b1;
          end else begin
            state_next = FTW_WAIT;
            hold_next = 1'b1;
            cnt_next = '0;
          end
        end
      end
      FTW_WAIT: begin
        if (!active || refill) begin
          state_next = FTW_IDLE;
          hold_next = 1'b0;
        end else if (tick) begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg + 3'h1 >= limit) begin
            state_next = FTW_END;
            hold_next = 1'b0;
            term_next = 1'b1;
          end
        end
      end
      FTW_END: begin
        // Stay until the cycle drops so one stall yields one end.
        if (!active) begin
          state_next = FTW_IDLE;
        end
      end
      default: begin
        state_next = FTW_IDLE;
        hold_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= FTW_IDLE;
      cnt_reg <= '0;
      hold_reg <= 1'b0;
      term_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
      term_reg <= term_next;
    end
  end

  assign hold = hold_reg;
  assign term = term_reg;
endmodule

// [bench/ftw_properties.sv]
// Purpose: Bus and wait-output properties of ftw_top.
// Assumes: No read overlaps a write to the same register.
// Notes: Read-back checks key on the last accepted read address.
`timescale 1ns/10ps
module ftw_props
  import ftw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [AXI_DW-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [REQ_N-1:0] req_high_group,
  input wire logic own_high_group,
  input wire logic wr_irdy_hold,
  input wire logic wr_cycle_end,
  input wire logic rd_trdy_hold,
  input wire logic rd_cycle_end
);
  logic [AXI_AW-1:0] ar_reg;
  logic [AXI_AW-1:0] ar_next;
  always_comb ar_next = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ar_reg <= '0;
    else ar_reg <= ar_next;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rst_groups;
    $rose(rstn) |-> own_high_group && req_high_group == '0;
  endproperty
  property p_arb_back;
    s_axi_rvalid && ar_reg == ARB_ADDR |-> s_axi_rdata[9:0] == {own_high_group, req_high_group};
  endproperty
  property p_arb_resv;
    s_axi_rvalid && ar_reg == ARB_ADDR |-> s_axi_rdata[31:10] == '0;
  endproperty
  property p_flow_resv;
    s_axi_rvalid && ar_reg == FLOW_ADDR |-> s_axi_rdata[31:7] == '0 && !s_axi_rdata[3];
  endproperty
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  property p_aw_busy;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  property p_wr_end;
    wr_cycle_end |-> !wr_irdy_hold ##1 !wr_cycle_end;
  endproperty
  property p_rd_end;
    rd_cycle_end |-> !rd_trdy_hold ##1 !rd_cycle_end;
  endproperty
  a_rst_groups: assert property (p_rst_groups) else $error("group reset wrong");
  a_arb_back: assert property (p_arb_back) else $error("group readback");
  a_arb_resv: assert property (p_arb_resv) else $error("arb high bits");
  a_flow_resv: assert property (p_flow_resv) else $error("flow bits 3/7");
  a_r_lat: assert property (p_r_lat) else $error("read late");
  a_b_lat: assert property (p_b_lat) else $error("write resp late");
  a_aw_busy: assert property (p_aw_busy) else $error("aw not busy");
  a_wr_end: assert property (p_wr_end) else $error("write end");
  a_rd_end: assert property (p_rd_end) else $error("read end");
  c_wr_end: cover property (wr_cycle_end);
  c_rd_end: cover property (rd_cycle_end);
  c_decerr: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
endmodule
bind ftw_top ftw_props u_props (
  .clk(clk),
  .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .req_high_group(req_high_group),
  .own_high_group(own_high_group),
  .wr_irdy_hold(wr_irdy_hold),
  .wr_cycle_end(wr_cycle_end),
  .rd_trdy_hold(rd_trdy_hold),
  .rd_cycle_end(rd_cycle_end)
);

// [bench/ftw_queue_model.sv]
// Purpose: Far-side queue status and PCI clock for ftw_top.
// Assumes: One stall at a time, chosen by wr_go or rd_go.
// Notes: The PCI clock stands low outside a stall so no stray ticks occur.
`timescale 1ns/10ps
module ftw_queue_model (
  input wire logic run,
  input wire logic wr_go,
  input wire logic rd_go,
  input wire logic give,
  output logic pci_clk,
  output logic wr_flow_active,
  output logic wr_one_entry_left,
  output logic wr_data_avail,
  output logic rd_flow_active,
  output logic rd_one_entry_left,
  output logic rd_space_avail
);
  initial begin
    pci_clk = 1'b0;
    forever begin
      #200;
      pci_clk = run ? !pci_clk : 1'b0;
    end
  end
  // Status starts idle and moves on the falling edge, settled at each rising edge.
  initial begin
    wr_flow_active = 1'b0;
    wr_one_entry_left = 1'b0;
    wr_data_avail = 1'b0;
    rd_flow_active = 1'b0;
    rd_one_entry_left = 1'b0;
    rd_space_avail = 1'b0;
    forever begin
      @(negedge pci_clk or negedge run);
      wr_flow_active <= run && wr_go;
      wr_one_entry_left <= run && wr_go;
      wr_data_avail <= run && wr_go && give;
      rd_flow_active <= run && rd_go;
      rd_one_entry_left <= run && rd_go;
      rd_space_avail <= run && rd_go && give;
    end
  end
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench for ftw_top.
// Assumes: Registers are reached one access at a time.
// Notes: A wait is counted as PCI clock rises seen while the hold is up.
`timescale 1ns/10ps
module testbench import ftw_pkg::*;;
  logic clk = 0;
  logic rstn = 0;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [AXI_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pci_clk, wr_flow_active, wr_one_entry_left, wr_data_avail;
  logic rd_flow_active, rd_one_entry_left, rd_space_avail;
  logic [REQ_N-1:0] req_high_group;
  logic own_high_group, wr_irdy_hold, wr_cycle_end, rd_trdy_hold, rd_cycle_end;
  logic run = 0, wr_go = 0, rd_go = 0, give = 0;
  int failures = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  ftw_top u_dut (
    .clk(clk),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .pci_clk(pci_clk),
    .wr_flow_active(wr_flow_active),
    .wr_one_entry_left(wr_one_entry_left),
    .wr_data_avail(wr_data_avail),
    .rd_flow_active(rd_flow_active),
    .rd_one_entry_left(rd_one_entry_left),
    .rd_space_avail(rd_space_avail),
    .req_high_group(req_high_group),
    .own_high_group(own_high_group),
    .wr_irdy_hold(wr_irdy_hold),
    .wr_cycle_end(wr_cycle_end),
    .rd_trdy_hold(rd_trdy_hold),
    .rd_cycle_end(rd_cycle_end)
  );
  ftw_queue_model u_model (
    .run(run),
    .wr_go(wr_go),
    .rd_go(rd_go),
    .give(give),
    .pci_clk(pci_clk),
    .wr_flow_active(wr_flow_active),
    .wr_one_entry_left(wr_one_entry_left),
    .wr_data_avail(wr_data_avail),
    .rd_flow_active(rd_flow_active),
    .rd_one_entry_left(rd_one_entry_left),
    .rd_space_avail(rd_space_avail)
  );
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s exp %h got %h", n, exp, got);
    end
  endtask
  task axw(input logic [AXI_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    fork
      begin
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 0;
      end
      begin
        do @(posedge clk); while (!s_axi_wready);
        s_axi_wvalid <= 0;
      end
    join
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task axr(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task wr_rd(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [31:0] e,
             input logic [1:0] er);
    logic [1:0] r;
    logic [31:0] q;
    axw(a, d, r);
    chk("bresp", 32'(r), 32'(er));
    axr(a, q, r);
    chk("rresp", 32'(r), 32'(er));
    chk("rdata", q, e);
  endtask
  task t_regs;
    logic [31:0] q;
    logic [1:0] r;
    axr(ARB_ADDR, q, r);
    chk("arb_rst", q, 32'h200);
    axr(FLOW_ADDR, q, r);
    chk("flow_rst", q, 32'h0);
    wr_rd(ARB_ADDR, 32'hFFFFFFFF, 32'h3FF, RESP_OKAY);
    chk("groups", 32'({own_high_group, req_high_group}), 32'h3FF);
    wr_rd(ARB_ADDR, 32'h155, 32'h155, RESP_OKAY);
    chk("groups", 32'({own_high_group, req_high_group}), 32'h155);
    // Only the low byte lane is enabled, so bits 15:8 keep their value.
    s_axi_wstrb <= 4'h1;
    wr_rd(ARB_ADDR, 32'h0000FFFF, 32'h1FF, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    chk("groups_strb", 32'({own_high_group, req_high_group}), 32'h1FF);
    wr_rd(FLOW_ADDR, 32'hFF, 32'h77, RESP_OKAY);
    wr_rd(12'h000, 32'h1, 32'h0, RESP_DECERR);
  endtask
  // With gv set, data arrives mid-wait, so the cycle must not end.
  task t_stall(input bit rd, input int code, input bit gv);
    logic [1:0] r;
    int n;
    int k;
    bit e;
    bit p;
    axw(FLOW_ADDR, 32'(code * 17), r);
    n = 0;
    e = 0;
    p = 0;
    wr_go <= !rd;
    rd_go <= rd;
    run <= 1;
    for (k = 0; k < 150 && !e; k++) begin
      @(posedge clk);
      if ((rd ? rd_trdy_hold : wr_irdy_hold) && pci_clk && !p) n++;
      e = rd ? rd_cycle_end : wr_cycle_end;
      if (gv && n == 3) give <= 1;
      p = pci_clk;
    end
    chk("end", 32'(e), 32'(!gv));
    if (gv) chk("hold", 32'(rd ? rd_trdy_hold : wr_irdy_hold), 32'h0);
    else chk("wait", n, code);
    run <= 0;
    wr_go <= 0;
    rd_go <= 0;
    give <= 0;
    repeat (10) @(posedge clk);
  endtask
  // Reset in mid-run must bring both registers and the group outputs back.
  task t_reset;
    logic [31:0] q;
    logic [1:0] r;
    @(posedge clk);
    rstn <= 0;
    repeat (4) @(posedge clk);
    rstn <= 1;
    axr(ARB_ADDR, q, r);
    chk("arb_rst2", q, 32'h200);
    chk("groups_rst", 32'({own_high_group, req_high_group}), 32'h200);
    axr(FLOW_ADDR, q, r);
    chk("flow_rst2", q, 32'h0);
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    t_regs;
    for (int c = 0; c < 8; c++) begin
      t_stall(0, c, 0);
      t_stall(1, c, 0);
    end
    t_stall(0, 7, 1);
    t_stall(1, 7, 1);
    t_reset;
    wrap_up;
  end
  initial begin
    #1000000;
    failures++;
    wrap_up;
  end
endmodule
